// ### rat_consts.svh
// rat_consts.svh: sizes and field positions of the reverse address translator
// assumes inclusion by bare name from every file of the block
`ifndef RAT_CONSTS_SVH
`define RAT_CONSTS_SVH
`define RAT_ADDR_W 32
`define RAT_ENTRIES 8
`define RAT_HALF 4
`define RAT_BLOCK_SHIFT 25
`define RAT_TAG_W 7
`define RAT_GRAN_SHIFT 20
`define RAT_FC_REGS 4
`endif

// ### rat_pkg.sv
// rat_pkg.sv: types shared by the reverse address translator files
// assumes rat_consts.svh is on the include path
`default_nettype none
`include "rat_consts.svh"
package rat_pkg;
  typedef logic [`RAT_TAG_W-1:0] rat_tag_type;
  typedef enum logic [3:0] {
    RAT_IDLE  = 4'h1,
    RAT_PICK  = 4'h2,
    RAT_PLACE = 4'h4,
    RAT_DONE  = 4'h8
  } rat_state_type;
endpackage : rat_pkg
`default_nettype wire

// ### rat_xlate_ram.sv
// rat_xlate_ram.sv: translation store with one lookup read port, one loader read port and one loader write port
// assumes a single clock; slot valid bits are flops so they clear at once
`timescale 1ns/10ps
`default_nettype none
`include "rat_consts.svh"
module rat_xlate_ram
  import rat_pkg::*;
#(
  parameter int IDX_W = 8,
  parameter int DAT_W = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // invalidate every slot
  input wire logic clear,
  // lookup read port
  input wire logic [IDX_W-1:0] rd_a_idx,
  output logic [DAT_W-1:0] rd_a_data,
  output logic rd_a_valid,
  // loader read port
  input wire logic [IDX_W-1:0] rd_b_idx,
  output logic [DAT_W-1:0] rd_b_data,
  output logic rd_b_valid,
  // loader write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DAT_W-1:0] wr_data
);
  localparam int DEPTH = 1 << IDX_W;

  logic [DAT_W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] slot_valid;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_a_data <= mem[rd_a_idx];
    rd_b_data <= mem[rd_b_idx];
  end

  // a write in the clearing cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_valid <= '0;
    end else begin
      if (clear) begin
        slot_valid <= '0;
      end
      if (wr_en) begin
        slot_valid[wr_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_a_valid <= 1'b0;
      rd_b_valid <= 1'b0;
    end else begin
      rd_a_valid <= slot_valid[rd_a_idx];
      rd_b_valid <= slot_valid[rd_b_idx];
    end
  end

  a_clear_all: assert property (@(posedge clk) disable iff (!rstn)
    (clear && !wr_en) |=> (slot_valid == '0))
    else $error("clear left a translation valid");

  a_write_sets: assert property (@(posedge clk) disable iff (!rstn)
    wr_en |=> slot_valid[$past(wr_idx)])
    else $error("written slot not valid");
endmodule : rat_xlate_ram
`default_nettype wire

// ### rat_top.sv
// rat_top.sv: reverse address translator, range table loader and bus-speed lookup
// assumes loader and bus inputs are synchronous to CORE_CLK
`timescale 1ns/10ps
`default_nettype none
`include "rat_consts.svh"
// Function
// - each physical granule keeps exactly one logical address.
// - among equal candidates the lowest logical address is kept.
// - a page-table candidate beats a transparent-register candidate.
// - a candidate inside the memory map beats one outside it.
// - the range table has eight entries, each one contiguous range.
// - each entry covers one fixed 32-Mbyte block, 256 Mbytes total.
// - memory-map ranges receive entries before page-table ranges.
// - memory-map ranges are placed by size, then address, smallest first.
// - remaining entries go to page-table ranges in ascending address order.
// - a whole-space mapping without map fills the lowest 256 Mbytes when shared, the lowest 128 Mbytes per half when split.
// - running out of entries flags out-of-resources, rest untranslated.
// - a map above 256 Mbytes exhausts the table before completion.
// - file loads use only file contents and ignore live setup.
// - in split mode entries 0-3 serve user, 4-7 supervisor.
// - equal root pointers and no function-code matching share all eight.
// - differing roots or function-code matching split into two halves.
// - lookup runs at bus speed, one answer per bus cycle.
// - enabled gives logical addresses, disabled gives raw physical ones.
// - a clear invalidates every stored translation at once.
module rat_top
  import rat_pkg::*;
#(
  parameter int MAX_RANGES = 16,
  parameter int GRAN_SHIFT = `RAT_GRAN_SHIFT
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // mode control
  input wire logic ENABLE,
  input wire logic CLEAR,
  input wire logic LOAD_FROM_FILE,
  input wire logic FILE_SPLIT,
  input wire logic [`RAT_ADDR_W-1:0] USER_ROOT,
  input wire logic [`RAT_ADDR_W-1:0] SUPER_ROOT,
  input wire logic [`RAT_FC_REGS-1:0] TTR_FC_MATCH,
  // range loading
  input wire logic RANGE_VALID,
  output logic RANGE_READY,
  input wire logic [`RAT_ADDR_W-1:0] RANGE_BASE,
  input wire logic [`RAT_ADDR_W-1:0] RANGE_LAST,
  input wire logic RANGE_IN_MAP,
  input wire logic RANGE_SUPER,
  input wire logic RANGE_FROM_FILE,
  input wire logic ALLOC_START,
  output logic ALLOC_DONE,
  output logic OUT_OF_RESOURCES,
  // translation loading
  input wire logic XL_VALID,
  output logic XL_READY,
  input wire logic [`RAT_ADDR_W-1:0] XL_PHYS,
  input wire logic [`RAT_ADDR_W-1:0] XL_LOGICAL,
  input wire logic XL_SUPER,
  input wire logic XL_FROM_TTR,
  input wire logic XL_IN_MAP,
  input wire logic XL_FROM_FILE,
  // processor bus
  input wire logic BUS_VALID,
  input wire logic [`RAT_ADDR_W-1:0] BUS_ADDR,
  input wire logic BUS_SUPER,
  // analyzer
  output logic ANA_VALID,
  output logic [`RAT_ADDR_W-1:0] ANA_ADDR,
  output logic ANA_TRANSLATED
);
  localparam int OFF_W = `RAT_BLOCK_SHIFT - GRAN_SHIFT;
  localparam int ENT_W = $clog2(`RAT_ENTRIES);
  localparam int IDX_W = ENT_W + OFF_W;
  localparam int LOG_W = `RAT_ADDR_W - GRAN_SHIFT;
  localparam int DAT_W = LOG_W + 2;
  localparam int RNG_W = $clog2(MAX_RANGES + 1);
  localparam int RID_W = $clog2(MAX_RANGES);
  localparam int KEY_W = 2 * `RAT_ADDR_W + 1;

  // entry membership of a table half
  function automatic logic in_half(input logic [ENT_W-1:0] ent, input logic sup,
                                   input logic spl);
    in_half = !spl || ((ent >= ENT_W'(`RAT_HALF)) == sup);
  endfunction : in_half

  function automatic logic [ENT_W-1:0] first_set(input logic [`RAT_ENTRIES-1:0] v);
    first_set = '0;
    for (int i = `RAT_ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = ENT_W'(i);
      end
    end
  endfunction : first_set

  // map ranges first, by size then base; others by base
  function automatic logic [KEY_W-1:0] range_key(input logic map,
                                                 input logic [`RAT_ADDR_W-1:0] base,
                                                 input logic [`RAT_ADDR_W-1:0] last);
    range_key = {!map, map ? (last - base) : {`RAT_ADDR_W{1'b0}}, base};
  endfunction : range_key

  // candidate a replaces stored b
  function automatic logic prefer(input logic [DAT_W-1:0] a, input logic [DAT_W-1:0] b);
    if (a[DAT_W-1] != b[DAT_W-1]) begin
      prefer = a[DAT_W-1];
    end else if (a[DAT_W-2] != b[DAT_W-2]) begin
      prefer = !a[DAT_W-2];
    end else begin
      prefer = a[LOG_W-1:0] < b[LOG_W-1:0];
    end
  endfunction : prefer

  rat_state_type state, next_state;
  logic [`RAT_ENTRIES-1:0] ent_valid;
  rat_tag_type ent_tag [`RAT_ENTRIES];
  logic split;
  logic oor;
  rat_tag_type cur_blk, end_blk;
  logic cur_super;

  logic [`RAT_ADDR_W-1:0] rng_base [MAX_RANGES];
  logic [`RAT_ADDR_W-1:0] rng_last [MAX_RANGES];
  logic [MAX_RANGES-1:0] rng_map, rng_super, rng_pend;
  logic [RNG_W-1:0] rng_count;

  logic pick_found;
  logic [RID_W-1:0] pick_idx;
  logic [KEY_W-1:0] pick_key;

  logic [`RAT_ENTRIES-1:0] plc_hit, plc_free, lk_hit, xl_hit;
  logic xl_busy;
  logic [IDX_W-1:0] xl_idx;
  logic [DAT_W-1:0] xl_new;
  logic s1_valid, s1_hit;
  logic [`RAT_ADDR_W-1:0] s1_addr;
  logic [DAT_W-1:0] rd_a_data, rd_b_data;
  logic rd_a_valid, rd_b_valid;

  wire alloc_go = (state == RAT_IDLE) && ALLOC_START;
  wire next_split = LOAD_FROM_FILE ? FILE_SPLIT :
                    ((USER_ROOT != SUPER_ROOT) || (|TTR_FC_MATCH));
  wire rng_take = RANGE_VALID && RANGE_READY;
  wire rng_keep = rng_take && (RANGE_FROM_FILE == LOAD_FROM_FILE);
  wire rng_map_left = |(rng_pend & rng_map);
  wire plc_any_hit = |plc_hit;
  wire plc_any_free = |plc_free;
  wire plc_write = (state == RAT_PLACE) && !plc_any_hit && plc_any_free;
  wire plc_fail = (state == RAT_PLACE) && !plc_any_hit && !plc_any_free;
  wire [ENT_W-1:0] plc_ent = first_set(plc_free);
  wire plc_last = (cur_blk == end_blk);
  wire rat_tag_type lk_tag = BUS_ADDR[`RAT_ADDR_W-1:`RAT_BLOCK_SHIFT];
  wire rat_tag_type xl_tag = XL_PHYS[`RAT_ADDR_W-1:`RAT_BLOCK_SHIFT];
  wire [ENT_W-1:0] lk_ent = first_set(lk_hit);
  wire lk_any = |lk_hit;
  wire [ENT_W-1:0] xl_ent = first_set(xl_hit);
  wire xl_take = XL_VALID && XL_READY;
  wire xl_go = xl_take && (|xl_hit) && (XL_FROM_FILE == LOAD_FROM_FILE);
  wire [IDX_W-1:0] lk_idx = {lk_ent, BUS_ADDR[`RAT_BLOCK_SHIFT-1:GRAN_SHIFT]};
  wire [IDX_W-1:0] xl_rd_idx = {xl_ent, XL_PHYS[`RAT_BLOCK_SHIFT-1:GRAN_SHIFT]};
  wire [DAT_W-1:0] xl_cand = {XL_IN_MAP, XL_FROM_TTR, XL_LOGICAL[`RAT_ADDR_W-1:GRAN_SHIFT]};
  wire xl_wr = xl_busy && (!rd_b_valid || prefer(xl_new, rd_b_data));
  wire lk_xlate = ENABLE && s1_hit && rd_a_valid;
  wire [`RAT_ADDR_W-1:0] lk_addr = {rd_a_data[LOG_W-1:0], s1_addr[GRAN_SHIFT-1:0]};

  assign RANGE_READY = (state == RAT_IDLE) && (rng_count < RNG_W'(MAX_RANGES));
  assign XL_READY = (state == RAT_IDLE) && !xl_busy;
  assign ALLOC_DONE = (state == RAT_DONE);
  assign OUT_OF_RESOURCES = oor;

  // eight 32-Mbyte block tags, searched per half when split, all eight when shared
  for (genvar g = 0; g < `RAT_ENTRIES; g++) begin : g_ent
    assign plc_hit[g] = ent_valid[g] && (ent_tag[g] == cur_blk) &&
                        in_half(ENT_W'(g), cur_super, split);
    assign plc_free[g] = !ent_valid[g] && in_half(ENT_W'(g), cur_super, split);
    assign lk_hit[g] = ent_valid[g] && (ent_tag[g] == lk_tag) &&
                       in_half(ENT_W'(g), BUS_SUPER, split);
    assign xl_hit[g] = ent_valid[g] && (ent_tag[g] == xl_tag) &&
                       in_half(ENT_W'(g), XL_SUPER, split);
  end

  // best pending range; lowest key wins
  always_comb begin
    pick_found = 1'b0;
    pick_idx = '0;
    pick_key = '1;
    for (int i = 0; i < MAX_RANGES; i++) begin
      if (rng_pend[i] && (!pick_found ||
          range_key(rng_map[i], rng_base[i], rng_last[i]) < pick_key)) begin
        pick_found = 1'b1;
        pick_idx = RID_W'(i);
        pick_key = range_key(rng_map[i], rng_base[i], rng_last[i]);
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      RAT_IDLE: begin
        if (ALLOC_START) begin
          next_state = RAT_PICK;
        end
      end
      RAT_PICK: begin
        next_state = pick_found ? RAT_PLACE : RAT_DONE;
      end
      RAT_PLACE: begin
        if (plc_fail || plc_last) begin
          next_state = RAT_PICK;
        end
      end
      RAT_DONE: begin
        next_state = RAT_IDLE;
      end
      default: begin
        next_state = RAT_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= RAT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // range store contents need no reset
  always_ff @(posedge CORE_CLK) begin
    if (rng_keep) begin
      rng_base[rng_count[RID_W-1:0]] <= RANGE_BASE;
      rng_last[rng_count[RID_W-1:0]] <= RANGE_LAST;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rng_count <= '0;
      rng_pend <= '0;
      rng_map <= '0;
      rng_super <= '0;
    end else if (state == RAT_DONE) begin
      rng_count <= '0;
      rng_pend <= '0;
    end else if (rng_keep) begin
      rng_count <= rng_count + 1'b1;
      rng_pend[rng_count[RID_W-1:0]] <= 1'b1;
      rng_map[rng_count[RID_W-1:0]] <= RANGE_IN_MAP;
      rng_super[rng_count[RID_W-1:0]] <= RANGE_SUPER;
    end else if (state == RAT_PICK && pick_found) begin
      rng_pend[pick_idx] <= 1'b0;
    end
  end

  // walk one block per cycle through the picked range
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur_blk <= '0;
      end_blk <= '0;
      cur_super <= 1'b0;
    end else if (state == RAT_PICK && pick_found) begin
      cur_blk <= rng_base[pick_idx][`RAT_ADDR_W-1:`RAT_BLOCK_SHIFT];
      end_blk <= rng_last[pick_idx][`RAT_ADDR_W-1:`RAT_BLOCK_SHIFT];
      cur_super <= rng_super[pick_idx];
    end else if (state == RAT_PLACE) begin
      cur_blk <= cur_blk + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ent_valid <= '0;
      for (int i = 0; i < `RAT_ENTRIES; i++) begin
        ent_tag[i] <= '0;
      end
    end else begin
      if (alloc_go || CLEAR) begin
        ent_valid <= '0;
      end
      if (plc_write) begin
        ent_valid[plc_ent] <= 1'b1;
        ent_tag[plc_ent] <= cur_blk;
      end
    end
  end

  // out-of-resources set wins over clear
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      split <= 1'b0;
      oor <= 1'b0;
    end else begin
      if (alloc_go) begin
        split <= next_split;
      end
      if (alloc_go || CLEAR) begin
        oor <= 1'b0;
      end
      if (plc_fail) begin
        oor <= 1'b1;
      end
    end
  end

  // candidate read-modify-write, one cycle of stall
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      xl_busy <= 1'b0;
      xl_idx <= '0;
      xl_new <= '0;
    end else begin
      xl_busy <= xl_go;
      if (xl_go) begin
        xl_idx <= xl_rd_idx;
        xl_new <= xl_cand;
      end
    end
  end

  // two-stage lookup, one bus cycle per clock
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_valid <= 1'b0;
      s1_hit <= 1'b0;
      s1_addr <= '0;
    end else begin
      s1_valid <= BUS_VALID;
      s1_hit <= lk_any;
      s1_addr <= BUS_ADDR;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ANA_VALID <= 1'b0;
      ANA_TRANSLATED <= 1'b0;
      ANA_ADDR <= '0;
    end else begin
      ANA_VALID <= s1_valid;
      ANA_TRANSLATED <= s1_valid && lk_xlate;
      ANA_ADDR <= lk_xlate ? lk_addr : s1_addr;
    end
  end

  rat_xlate_ram #(
    .IDX_W(IDX_W),
    .DAT_W(DAT_W)
  ) u_store (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .clear(CLEAR || alloc_go),
    .rd_a_idx(lk_idx),
    .rd_a_data(rd_a_data),
    .rd_a_valid(rd_a_valid),
    .rd_b_idx(xl_rd_idx),
    .rd_b_data(rd_b_data),
    .rd_b_valid(rd_b_valid),
    .wr_en(xl_wr),
    .wr_idx(xl_idx),
    .wr_data(xl_new)
  );

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence seq_bus_disabled;
    BUS_VALID ##1 !ENABLE;
  endsequence

  a_lookup_latency: assert property (
    BUS_VALID |-> ##2 ANA_VALID)
    else $error("bus cycle not answered two cycles later");

  a_disabled_raw: assert property (
    seq_bus_disabled |-> ##1 (!ANA_TRANSLATED && ANA_ADDR == $past(BUS_ADDR, 2)))
    else $error("disabled translator altered the address");

  a_untranslated_raw: assert property (
    (ANA_VALID && !ANA_TRANSLATED) |-> (ANA_ADDR == $past(BUS_ADDR, 2)))
    else $error("untranslated address was changed");

  a_map_first: assert property (
    (state == RAT_PICK && pick_found && rng_map_left) |-> rng_map[pick_idx])
    else $error("page-table range placed before map range");

  a_half_place: assert property (
    plc_write |-> in_half(plc_ent, cur_super, split))
    else $error("entry placed in wrong half");

  a_half_lookup: assert property (
    (BUS_VALID && split && lk_any) |-> ((lk_ent >= ENT_W'(`RAT_HALF)) == BUS_SUPER))
    else $error("lookup searched wrong half");

  a_shared_table: assert property (
    (alloc_go && !LOAD_FROM_FILE && USER_ROOT == SUPER_ROOT && TTR_FC_MATCH == '0)
    |=> !split)
    else $error("table split though spaces are shared");

  a_split_table: assert property (
    (alloc_go && !LOAD_FROM_FILE && (USER_ROOT != SUPER_ROOT || TTR_FC_MATCH != '0))
    |=> split)
    else $error("table not split");

  a_out_of_res: assert property (
    $rose(oor) |-> $past(plc_fail))
    else $error("out-of-resources without placement failure");

  a_file_only: assert property (
    (xl_take && XL_FROM_FILE != LOAD_FROM_FILE) |=> !xl_busy)
    else $error("translation from unselected source used");
endmodule : rat_top
`default_nettype wire

// ### rat_bus_src.sv
// rat_bus_src.sv: processor bus side model that issues single bus cycles
// assumes the bench calls issue() and shares CORE_CLK with the translator
`timescale 1ns/10ps
`default_nettype none
`include "rat_consts.svh"
module rat_bus_src (
  // clock
  input wire logic clk,
  // bus cycle
  output logic bus_valid,
  output logic [`RAT_ADDR_W-1:0] bus_addr,
  output logic bus_super
);
  initial begin
    bus_valid = 1'b0;
    bus_addr = 32'h0;
    bus_super = 1'b0;
  end

  // one cycle, then scramble the lines so stale values never look valid
  task automatic issue(input logic [`RAT_ADDR_W-1:0] a, input logic s);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_super <= s;
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_addr <= ~a;
    bus_super <= ~s;
  endtask : issue
endmodule : rat_bus_src
`default_nettype wire

// ### tb_rat_top.sv
// tb_rat_top.sv: self-checking bench for the reverse address translator
// assumes rat_bus_src drives the bus; model state kept in plain arrays
`timescale 1ns/10ps
`default_nettype none
`include "rat_consts.svh"
module tb_rat_top
  import rat_pkg::*;
;
  logic clk, rstn, en, clr, lff, fsplit, rv, rin, rsup, rfile, start;
  logic xv, xsup, xttr, xmap, xfile;
  logic [31:0] uroot, sroot, rbase, rlast, xphys, xlog;
  logic [3:0] ttr;
  wire logic rrdy, done, oor, xrdy, bv, bsup, av, atr;
  wire logic [31:0] ba, aa;
  int n_mismatch, samples_checked, r, seed;
  bit [6:0] eblk[8];
  bit evld[8], xh[256], xm[256], xt[256];
  bit [31:0] xl[256], p;
  bit msplit, moor;
  bit [31:0] qb[$], ql[$];
  bit qm[$], qs[$];

  rat_top dut (.CORE_CLK(clk), .RSTN(rstn), .ENABLE(en), .CLEAR(clr), .LOAD_FROM_FILE(lff),
    .FILE_SPLIT(fsplit), .USER_ROOT(uroot), .SUPER_ROOT(sroot), .TTR_FC_MATCH(ttr),
    .RANGE_VALID(rv), .RANGE_READY(rrdy), .RANGE_BASE(rbase), .RANGE_LAST(rlast),
    .RANGE_IN_MAP(rin), .RANGE_SUPER(rsup), .RANGE_FROM_FILE(rfile), .ALLOC_START(start),
    .ALLOC_DONE(done), .OUT_OF_RESOURCES(oor), .XL_VALID(xv), .XL_READY(xrdy),
    .XL_PHYS(xphys), .XL_LOGICAL(xlog), .XL_SUPER(xsup), .XL_FROM_TTR(xttr),
    .XL_IN_MAP(xmap), .XL_FROM_FILE(xfile), .BUS_VALID(bv), .BUS_ADDR(ba),
    .BUS_SUPER(bsup), .ANA_VALID(av), .ANA_ADDR(aa), .ANA_TRANSLATED(atr));
  rat_bus_src u_bus (.clk(clk), .bus_valid(bv), .bus_addr(ba), .bus_super(bsup));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task test_done;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task guard(input int i, input int lim);
    if (i >= lim) begin
      n_mismatch++;
      test_done;
    end
  endtask : guard

  function automatic bit [64:0] rkey(int i);
    return qm[i] ? {1'b0, ql[i] - qb[i], qb[i]} : {1'b1, 32'h0, qb[i]};
  endfunction : rkey

  function automatic int ent_of(bit [6:0] b, bit s);
    int e, lo, hi;
    lo = (msplit && s) ? 4 : 0;
    hi = msplit ? lo + 3 : 7;
    for (e = lo; e <= hi; e++) if (evld[e] && eblk[e] == b) return e;
    return -1;
  endfunction : ent_of

  task automatic put_range(input bit [31:0] b, l, input bit m, s, f);
    int i;
    @(posedge clk);
    rv <= 1'b1;
    rbase <= b;
    rlast <= l;
    rin <= m;
    rsup <= s;
    rfile <= f;
    i = 0;
    do begin @(negedge clk); i++; end while (rrdy !== 1'b1 && i < 200);
    guard(i, 200);
    @(posedge clk);
    rv <= 1'b0;
    // ranges of the wrong source are taken but dropped
    if (f == lff) begin
      qb.push_back(b);
      ql.push_back(l);
      qm.push_back(m);
      qs.push_back(s);
    end
  endtask : put_range

  task automatic alloc;
    int i, k, b, e, lo, hi;
    bit hit;
    bit [31:0] cb, cl;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    i = 0;
    do begin @(negedge clk); i++; end while (done !== 1'b1 && i < 2000);
    guard(i, 2000);
    msplit = lff ? fsplit : (uroot != sroot || ttr != 4'h0);
    moor = 0;
    evld = '{default: 0};
    xh = '{default: 0};
    while (qb.size() > 0) begin
      k = 0;
      for (i = 1; i < qb.size(); i++) if (rkey(i) < rkey(k)) k = i;
      cb = qb[k];
      cl = ql[k];
      lo = (msplit && qs[k]) ? 4 : 0;
      hi = msplit ? lo + 3 : 7;
      for (b = cb[31:25]; b <= cl[31:25]; b++) begin
        hit = 0;
        for (e = lo; e <= hi; e++) if (evld[e] && eblk[e] == b[6:0]) hit = 1;
        for (e = lo; e <= hi && !hit; e++) if (!evld[e]) begin
          evld[e] = 1;
          eblk[e] = b[6:0];
          hit = 1;
        end
        if (!hit) begin
          moor = 1;
          break;
        end
      end
      qb.delete(k);
      ql.delete(k);
      qm.delete(k);
      qs.delete(k);
    end
    @(negedge clk);
    chk(oor, moor);
  endtask : alloc

  task automatic put_xl(input bit [31:0] ph, lg, input bit s, t, m, f);
    int i, k;
    @(posedge clk);
    xv <= 1'b1;
    xphys <= ph;
    xlog <= lg;
    xsup <= s;
    xttr <= t;
    xmap <= m;
    xfile <= f;
    i = 0;
    do begin @(negedge clk); i++; end while (xrdy !== 1'b1 && i < 200);
    guard(i, 200);
    @(posedge clk);
    xv <= 1'b0;
    i = ent_of(ph[31:25], s);
    if (i < 0 || f != lff) return;
    k = i * 32 + ph[24:20];
    if (!xh[k] || (m != xm[k] ? m : (t != xt[k] ? !t : lg[31:20] < xl[k][31:20]))) begin
      xh[k] = 1;
      xm[k] = m;
      xt[k] = t;
      xl[k] = lg;
    end
  endtask : put_xl

  task automatic look(input bit [31:0] a, input bit s);
    int e;
    bit [31:0] ea;
    bit et;
    u_bus.issue(a, s);
    e = ent_of(a[31:25], s);
    et = 0;
    if (e >= 0) et = en && xh[e * 32 + a[24:20]];
    ea = et ? {xl[e * 32 + a[24:20]][31:20], a[19:0]} : a;
    @(negedge clk);
    chk(av, 1'b0);
    @(negedge clk);
    chk(av, 1'b1);
    chk(aa, ea);
    chk(atr, et);
  endtask : look

  // one translation per block 0-19, then a bus cycle on it
  task automatic probe(input bit s);
    int b;
    bit [31:0] ph;
    for (b = 0; b < 20; b++) begin
      ph = {b[6:0], 5'($urandom), 20'($urandom)};
      put_xl(ph, {12'($urandom), 20'h0}, s, 1'b0, 1'b0, lff);
      look(ph, s);
    end
  endtask : probe

  initial begin
    rstn = 1'b0;
    en = 1'b1;
    clr = 1'b0;
    lff = 1'b0;
    fsplit = 1'b0;
    uroot = 32'h0000_1000;
    sroot = 32'h0000_1000;
    ttr = 4'h0;
    {rv, rin, rsup, rfile, start, xv, xsup, xttr, xmap, xfile} = '0;
    rbase = 32'h0;
    rlast = 32'h0;
    xphys = 32'h0;
    xlog = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    seed = $urandom(32'h833A3BDF);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    put_range(32'h0, 32'hFFFF_FFFF, 1'b0, 1'b0, 1'b0);
    alloc;
    probe(1'b0);
    $display("test whole_space done");
    put_range(32'h0000_0000, 32'h003F_FFFF, 1'b1, 1'b0, 1'b0);
    put_range(32'h1000_0000, 32'h101F_FFFF, 1'b1, 1'b0, 1'b0);
    put_range(32'h2000_0000, 32'h203F_FFFF, 1'b1, 1'b0, 1'b0);
    put_range(32'h0, 32'hFFFF_FFFF, 1'b0, 1'b0, 1'b0);
    alloc;
    probe(1'b0);
    $display("test map_priority done");
    put_range(32'h0, 32'h13FF_FFFF, 1'b1, 1'b0, 1'b0);
    alloc;
    probe(1'b1);
    $display("test big_map done");
    put_range(32'h0, 32'h01FF_FFFF, 1'b0, 1'b0, 1'b0);
    alloc;
    repeat (24) begin
      put_xl(32'h0010_0000, {10'h0, 2'($urandom), 20'h0}, 1'b0, 1'($urandom), 1'($urandom), 1'b0);
      look(32'h0010_0ABC, 1'b0);
    end
    $display("test precedence done");
    for (r = 0; r < 8; r++) begin
      @(posedge clk);
      lff <= (r % 4 == 3);
      fsplit <= 1'($urandom);
      ttr <= (r % 4 == 2) ? 4'(1 << (r / 4)) : 4'h0;
      sroot <= (r % 4 == 1) ? 32'h0000_2000 : 32'h0000_1000;
      repeat (2 + $urandom % 5) begin
        p = {4'h0, 3'($urandom), 25'($urandom)};
        put_range(p, p + ($urandom % 32'h0600_0000), 1'($urandom), 1'($urandom),
          (r % 4 == 3) ^ ($urandom % 8 == 0));
      end
      alloc;
      repeat (20) begin
        p = {4'h0, 3'($urandom % 6), 25'($urandom)};
        put_xl(p, {10'h0, 2'($urandom), 20'h0}, 1'($urandom), 1'($urandom), 1'($urandom),
          (r % 4 == 3) ^ ($urandom % 8 == 0));
        en <= ($urandom % 4 != 0);
        look(p, 1'($urandom));
      end
      if (r % 2 == 1) begin
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        evld = '{default: 0};
        xh = '{default: 0};
        look(p, 1'b0);
        chk(oor, 1'b0);
      end
      $display("test random_round %0d done", r);
    end
    test_done;
  end
endmodule : tb_rat_top
`default_nettype wire
